// file: core/eeb_pkg.sv
package eeb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;  // System clock rate
  localparam int unsigned TWR_MS = 5;  // Longest internal write cycle, ms
  // Longest time, rounded down to whole cycles
  localparam int unsigned TWR_CYCLES = TWR_MS * (CLK_HZ / 1000);
  localparam int WCW = 17;  // Write cycle counter width

  // ----------------------------------------------------------------
  // Array and frame layout
  // ----------------------------------------------------------------
  localparam int AW = 13;  // Word address width
  localparam int DEPTH = 8192;  // Array bytes
  localparam int PAGE = 32;  // Page bytes
  localparam int PW = 5;  // In-page address bits
  localparam int CW = 6;  // Copy index width
  localparam logic [7:0] ERASED = 8'hFF;  // Erased byte value
  localparam logic [3:0] FIRST_CNT = 4'h1;  // Count after first bit
  localparam logic [3:0] LAST_BIT = 4'h7;  // Count when bit 0 is sampled
  localparam logic [3:0] ACK_BIT = 4'h8;  // Count in the ninth clock

  // Link side states, Gray along the usual path
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_DEV = 3'b001,
    L_WAH = 3'b011,
    L_WAL = 3'b010,
    L_WD = 3'b110,
    L_RD = 3'b111
  } eeb_link_e;

  // System side states
  typedef enum logic {
    S_IDLE = 1'b0,
    S_WR = 1'b1
  } eeb_sys_e;

  // Slave address strap pins
  typedef struct packed {
    logic addr_strap_bit2;
    logic addr_strap_bit1;
    logic addr_strap_bit0;
  } eeb_strap_s;

  // Status levels
  typedef struct packed {
    logic busy;
    logic wr_cancel;
  } eeb_stat_s;

endpackage

// file: core/eeb_target.sv
`timescale 1ns/1ps
// Behaviour
// R1 - Start is SDA fall with SCL high
// R2 - Stop is SDA rise with SCL high
// R3 - Write without stop is discarded
// R4 - Upper four address bits match type code
// R5 - Next three bits match strap pins
// R6 - Address bit zero selects read or write
// R7 - Write protect high blocks every write
// R8 - Protect high after data bit cancels write
// R9 - Protect ignored before first data bit
// R10 - Protect high aborts running write cycle
// R11 - Receiver pulls SDA low on ninth clock
// R12 - Acknowledge address, word address, data bytes
// R13 - Read continues on ack, stops on nack
// R14 - Stop starts write cycle, bus ignored
// R15 - Page write increments low five bits
// R16 - Page address wraps, later bytes overwrite
// R17 - Current read follows last accessed address
// R18 - Acknowledged reads stream successive bytes
// R19 - Random read uses dummy write first
// R20 - Master nacks last byte then stops
// R21 - Master polls with address for completion
// R22 - Master may reset with dummy clocks
// R23 - Sample on SCL rise, drive after fall
// R24 - Start then stop cancels the command
// R25 - Word address two bytes, high first
// R26 - Read address wraps to zero
module eeb_target #(
  parameter logic [3:0] DEV_TYPE = 4'h6,  // Arbitrary type code value
  parameter int WR_CYCLES = eeb_pkg::TWR_CYCLES  // Write cycle length
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp,
  input wire eeb_pkg::eeb_strap_s strap,
  output eeb_pkg::eeb_stat_s status
);
  import eeb_pkg::*;

  localparam logic [WCW-1:0] WC_LAST = WCW'(WR_CYCLES - 1);  // Last cycle
  localparam logic [CW-1:0] C_END = CW'(PAGE);  // Copy done index

  // ----------------------------------------------------------------
  // Shared storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:DEPTH-1];  // Array, written on clock only
  logic [7:0] pbuf [0:PAGE-1];  // Page buffer, written on scl only
  logic [PAGE-1:0] vld;  // Buffered byte marks
  logic [AW-1:0] addr;  // Address counter
  logic [2:0] lrst;  // Reset synchroniser on scl
  logic busy_s1, busy_s2;  // Busy level on scl
  eeb_strap_s strap_s1, strap_s2;  // Strap levels on scl

  // ----------------------------------------------------------------
  // Start and stop detectors on SDA edges
  // ----------------------------------------------------------------
  logic start_tog, next_start_tog;  // Flips on each start
  logic stop_tog, next_stop_tog;  // Flips on each stop

  // Start: SDA falls with SCL high
  always_comb begin
    next_start_tog = 1'b0;
    if (lrst[1]) begin
      next_start_tog = start_tog ^ scl;  // R1
    end
  end

  always_ff @(negedge sda_in) begin
    start_tog <= next_start_tog;
  end

  // Stop: SDA rises with SCL high
  always_comb begin
    next_stop_tog = 1'b0;
    if (lrst[1]) begin
      next_stop_tog = stop_tog ^ scl;  // R2
    end
  end

  always_ff @(posedge sda_in) begin
    stop_tog <= next_stop_tog;
  end

  // ----------------------------------------------------------------
  // Link side synchronisers
  // ----------------------------------------------------------------
  // Busy and straps pass two flops on scl, reset three (detectors tap the second)
  always_ff @(posedge scl) begin
    lrst <= {lrst[1:0], resetn};
    busy_s1 <= status.busy;
    busy_s2 <= busy_s1;
    strap_s1 <= strap;
    strap_s2 <= strap_s1;
  end

  // ----------------------------------------------------------------
  // Link receive logic, rising SCL
  // ----------------------------------------------------------------
  eeb_link_e st, next_st;  // Frame state
  logic [3:0] cnt, next_cnt;  // Bits seen in this byte
  logic [7:0] sh, next_sh;  // Receive shift register
  logic [PW-1:0] hi, next_hi;  // Word address high part
  logic [AW-1:0] next_addr;
  logic first, next_first;  // No data byte yet
  logic pend, next_pend;  // Data waits for stop
  logic arm, next_arm;  // Protect window open
  logic start_seen, next_start_seen;  // Last start handled
  logic [7:0] next_pbuf [0:PAGE-1];
  logic [PAGE-1:0] next_vld;
  logic start_new;  // Start since last rise
  logic match;  // Address byte is ours
  logic [PW-1:0] widx;  // Buffer slot of this byte

  assign start_new = start_tog ^ start_seen;
  assign match = (sh[7:4] == DEV_TYPE) && (sh[3:1] == strap_s2);  // R4 R5
  assign widx = first ? addr[PW-1:0] : addr[PW-1:0] + 5'h1;  // R15 R16

  // Next values of the receive side
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sh = sh;
    next_hi = hi;
    next_addr = addr;
    next_first = first;
    next_pend = pend;
    next_arm = arm;
    next_start_seen = start_tog;
    next_pbuf = pbuf;
    next_vld = vld;
    if (!lrst[2]) begin
      // Reset values
      next_st = L_IDLE;
      next_cnt = '0;
      next_sh = '0;
      next_hi = '0;
      next_addr = '0;
      next_first = 1'b1;
      next_pend = 1'b0;
      next_arm = 1'b0;
      next_vld = '0;
    end else if (start_new) begin
      // New frame; unstopped data is dropped
      next_st = L_DEV;  // R1
      next_cnt = FIRST_CNT;
      next_sh = {sh[6:0], sda_in};  // R23
      next_pend = 1'b0;  // R3 R24
      next_arm = 1'b0;  // R9
    end else if (st != L_IDLE && cnt != ACK_BIT) begin
      // Data bit
      next_sh = {sh[6:0], sda_in};  // R23
      next_cnt = cnt + 4'h1;
      if (st == L_WD && cnt == LAST_BIT) begin
        next_arm = 1'b1;  // R8
      end
    end else begin
      // Ninth clock
      next_cnt = '0;
      case (st)
        L_DEV: begin
          next_st = L_IDLE;  // R5
          if (match && !busy_s2) begin
            if (sh[0]) begin
              next_st = L_RD;  // R6
            end else begin
              next_st = L_WAH;  // R6
              next_vld = '0;
              next_first = 1'b1;
            end
          end
        end
        L_WAH: begin
          next_hi = sh[PW-1:0];  // R25
          next_st = L_WAL;
        end
        L_WAL: begin
          next_addr = {hi, sh};  // R25
          next_st = L_WD;
        end
        L_WD: begin
          next_addr[PW-1:0] = widx;  // R15 R17
          next_pbuf[widx] = sh;  // R16
          next_vld[widx] = 1'b1;
          next_pend = 1'b1;
          next_first = 1'b0;
        end
        L_RD: begin
          next_addr = addr + 13'h1;  // R17 R26
          if (sda_in) begin
            next_st = L_IDLE;  // R13
          end
        end
        default: begin
          next_st = L_IDLE;
        end
      endcase
    end
  end

  // Receive side registers
  always_ff @(posedge scl) begin
    st <= next_st;
    cnt <= next_cnt;
    sh <= next_sh;
    hi <= next_hi;
    addr <= next_addr;
    first <= next_first;
    pend <= next_pend;
    arm <= next_arm;
    start_seen <= next_start_seen;
    pbuf <= next_pbuf;
    vld <= next_vld;
  end

  // ----------------------------------------------------------------
  // Link drive logic, falling SCL
  // ----------------------------------------------------------------
  logic drv_low, next_drv_low;  // Pull SDA low
  logic rd_bit;  // Bit to send

  assign rd_bit = mem[addr][3'(LAST_BIT - cnt)];

  // Acknowledge and read data, changed after the fall only
  always_comb begin
    next_drv_low = 1'b0;
    if (lrst[2] && !start_new) begin
      if (cnt == ACK_BIT) begin
        next_drv_low = (st == L_DEV && match && !busy_s2)  // R11 R12 R14
          || st == L_WAH || st == L_WAL || st == L_WD;  // R12
      end else if (st == L_RD) begin
        next_drv_low = !rd_bit;  // R18 R23
      end
    end
  end

  always_ff @(negedge scl) begin
    drv_low <= next_drv_low;
  end

  // ----------------------------------------------------------------
  // System side synchronisers
  // ----------------------------------------------------------------
  logic [2:0] stop_s;  // Two flops plus edge history
  logic [1:0] pend_s, arm_s, wp_s;
  logic stop_ev;  // One cycle per stop

  always_ff @(posedge clock) begin
    stop_s <= {stop_s[1:0], stop_tog};
    pend_s <= {pend_s[0], pend};
    arm_s <= {arm_s[0], arm};
    wp_s <= {wp_s[0], wp};
  end

  assign stop_ev = stop_s[2] ^ stop_s[1];

  // ----------------------------------------------------------------
  // Internal write cycle
  // ----------------------------------------------------------------
  eeb_sys_e sst, next_sst;  // Write cycle state
  logic [WCW-1:0] wcnt, next_wcnt;  // Cycles in write
  logic [CW-1:0] cidx, next_cidx;  // Next buffer slot to copy
  logic cancel, next_cancel;  // Protect seen in window
  logic link_up, next_link_up;  // Out of reset
  logic we;  // Array write strobe
  logic [AW-1:0] waddr;  // Array write address

  assign waddr = {addr[AW-1:PW], cidx[PW-1:0]};
  assign we = sst == S_WR && !wp_s[1] && cidx != C_END && vld[cidx[PW-1:0]];  // R7

  // Next values of the write cycle
  always_comb begin
    next_sst = sst;
    next_wcnt = wcnt;
    next_cidx = cidx;
    next_cancel = arm_s[1] && (cancel || wp_s[1]);  // R8 R9
    next_link_up = 1'b1;
    if (!resetn) begin
      next_sst = S_IDLE;
      next_wcnt = '0;
      next_cidx = '0;
      next_cancel = 1'b0;
      next_link_up = 1'b0;
    end else begin
      case (sst)
        S_IDLE: begin
          if (stop_ev && pend_s[1] && !cancel && !wp_s[1]) begin
            next_sst = S_WR;  // R14 R7
            next_wcnt = '0;
            next_cidx = '0;
          end
        end
        S_WR: begin
          if (wp_s[1]) begin
            next_sst = S_IDLE;  // R10
          end else begin
            next_wcnt = wcnt + 17'h1;
            if (cidx != C_END) begin
              next_cidx = cidx + 6'h1;
            end
            if (wcnt >= WC_LAST && cidx == C_END) begin
              next_sst = S_IDLE;  // R14
            end
          end
        end
        default: begin
          next_sst = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    sst <= next_sst;
    wcnt <= next_wcnt;
    cidx <= next_cidx;
    cancel <= next_cancel;
    link_up <= next_link_up;
  end

  // Array: erased at reset, one buffered byte per cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED;
      end
    end else if (we) begin
      mem[waddr] <= pbuf[cidx[PW-1:0]];  // R15
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe = !(drv_low && link_up);  // Low while pulling
  assign status.busy = (sst == S_WR);
  assign status.wr_cancel = cancel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_start_frame: assert property (  // R1
    @(posedge scl) disable iff (!lrst[2])
    start_new |=> st == L_DEV && cnt == FIRST_CNT)
    else $error("start did not open a frame");

  a_foreign_idle: assert property (  // R4
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && st == L_DEV && cnt == ACK_BIT && !match) |=> st == L_IDLE)
    else $error("foreign address not ignored");

  a_read_dir: assert property (  // R6
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && st == L_DEV && cnt == ACK_BIT && match && !busy_s2 && sh[0])
    |=> st == L_RD ##1 cnt == FIRST_CNT)
    else $error("read direction not taken");

  a_byte_ack: assert property (  // R12
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && cnt == ACK_BIT && (st == L_WAH || st == L_WAL || st == L_WD))
    |-> drv_low)
    else $error("write byte not acknowledged");

  a_busy_noack: assert property (  // R14
    @(posedge scl) disable iff (!lrst[2])
    (st == L_DEV && cnt == ACK_BIT && busy_s2) |-> !drv_low)
    else $error("acknowledge while busy");

  a_page_wrap: assert property (  // R15
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && st == L_WD && cnt == ACK_BIT && !first)
    |=> addr[AW-1:PW] == $past(addr[AW-1:PW])
    && addr[PW-1:0] == 5'($past(addr[PW-1:0]) + 5'h1))
    else $error("page address step wrong");

  a_read_step: assert property (  // R17
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && st == L_RD && cnt == ACK_BIT) |=> addr == 13'($past(addr) + 13'h1))
    else $error("read address not advanced");

  a_nack_end: assert property (  // R13
    @(posedge scl) disable iff (!lrst[2])
    (!start_new && st == L_RD && cnt == ACK_BIT && sda_in) |=> st == L_IDLE)
    else $error("read went on after nack");

  a_wp_abort: assert property (  // R10
    @(posedge clock) disable iff (!resetn)
    (sst == S_WR && wp_s[1]) |=> sst == S_IDLE && !we)
    else $error("protect did not abort write");

  a_commit_stop: assert property (  // R14
    @(posedge clock) disable iff (!resetn)
    (sst == S_IDLE && stop_ev && pend_s[1] && !cancel && !wp_s[1])
    |=> sst == S_WR && wcnt == '0)
    else $error("stop did not start write");

  a_wr_bound: assert property (  // R14
    @(posedge clock) disable iff (!resetn)
    sst == S_WR |-> wcnt <= WC_LAST + 17'h1 || cidx != C_END)
    else $error("write cycle overran");

endmodule

// file: testbench/eeb_bus_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-wire bus master model; link clock stands still between frames
// ----------------------------------------------------------------
module eeb_bus_master (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  localparam realtime Q = 31.25;  // Quarter of the 125 ns link period

  // Idle bus, both lines released to the pull-up
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Start, also a repeated start from clock low
  task automatic start();
    #(Q) sda_rel = 1'b1;
    #(Q) scl = 1'b1;
    #(Q) sda_rel = 1'b0;
    #(Q) scl = 1'b0;
  endtask

  // Stop, leaves both lines high
  task automatic stop();
    #(Q) sda_rel = 1'b0;
    #(Q) scl = 1'b1;
    #(Q) sda_rel = 1'b1;
    #(Q);
  endtask

  // One clock: set data while low, sample the wire in the middle of the high phase
  task automatic clk_bit(input logic b, output logic s);
    #(Q) sda_rel = b;
    #(Q) scl = 1'b1;
    #(Q) s = sda;
    #(Q) scl = 1'b0;
  endtask

  // Byte out MSB first, then release for the target's ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack);
  endtask

  // Byte in with the line released, then our ack level
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(mack, s);
  endtask
endmodule

// file: testbench/test_serial_eeprom_bus_target.sv
`timescale 1ns/1ps
module test_serial_eeprom_bus_target;
  import eeb_pkg::*;
  localparam logic [3:0] TYPE_C = 4'h5;  // Arbitrary type code value
  logic clock, resetn, wp, scl, sda_rel, sda_out, sda_oe, ack, acc, first;
  wire logic sda;
  eeb_strap_s strap;
  eeb_stat_s status;
  int err_total, comparisons, cycles, ptr, a;
  int mem[DEPTH];  // Reference array
  logic [31:0] lfsr;
  logic [7:0] dev, rd, t;
  logic [7:0] q[$];  // Bytes of the next write

  // Open-drain wire with pull-up
  assign sda = sda_rel & (sda_oe ? 1'b1 : sda_out);

  eeb_target #(.DEV_TYPE(TYPE_C), .WR_CYCLES(40)) u_dut (
    .clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp(wp), .strap(strap), .status(status));
  eeb_bus_master u_mst (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("TB: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0040_0007 : 32'h0000_0000);
    return lfsr[7:0];
  endfunction

  task automatic drive_wp(input logic v);
    @(negedge clock);
    wp = v;
  endtask

  task automatic addr_phase(input logic rw, output logic k);
    u_mst.start();
    u_mst.wbyte({dev[7:1], rw}, k);
  endtask

  // Write command without its stop; junk in the unused word address bits
  task automatic wr_frame(input int wa);
    addr_phase(1'b0, acc);
    u_mst.wbyte({3'b101, wa[12:8]}, ack);
    acc = acc | ack;
    u_mst.wbyte(wa[7:0], ack);
    acc = acc | ack;
    foreach (q[i]) begin
      u_mst.wbyte(q[i], ack);
      acc = acc | ack;
    end
    check({7'h00, acc}, 8'h00, "write acks");
  endtask

  task automatic fill(input int n);
    q.delete();
    repeat (n) q.push_back(rnd());
  endtask

  // Full write; model updated only when it should commit
  task automatic wr(input int wa, input int n, input bit keep);
    fill(n);
    wr_frame(wa);
    u_mst.stop();
    if (keep) begin
      foreach (q[i]) begin
        ptr = (wa & ~31) | ((wa + i) & 31);
        mem[ptr] = q[i];
      end
    end
  endtask

  // Acknowledge polling; first try must be refused while busy
  task automatic poll();
    int n;
    n = 0;
    ack = 1'b1;
    while (ack !== 1'b0 && n < 30) begin
      addr_phase(1'b0, ack);
      if (n == 0) first = ack;
      u_mst.stop();
      n++;
    end
    check({7'h00, first}, 8'h01, "busy ack");
    check({7'h00, ack}, 8'h00, "poll ack");
  endtask

  task automatic rd_seq(input int n);
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i == n - 1, rd);
      check(rd, mem[ptr][7:0], "read data");
      ptr = (ptr + 1) % DEPTH;
    end
    u_mst.stop();
  endtask

  task automatic rd_cur(input int n);
    addr_phase(1'b1, ack);
    check({7'h00, ack}, 8'h00, "read addr ack");
    rd_seq(n);
  endtask

  task automatic rd_rand(input int ra, input int n);
    addr_phase(1'b0, acc);
    u_mst.wbyte({3'b000, ra[12:8]}, ack);
    acc = acc | ack;
    u_mst.wbyte(ra[7:0], ack);
    addr_phase(1'b1, first);
    check({7'h00, acc | ack | first}, 8'h00, "dummy write acks");
    ptr = ra;
    rd_seq(n);
  endtask

  function automatic int rnd_addr();
    return int'({rnd(), rnd()}) % DEPTH;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    wp = 1'b0;
    lfsr = 32'h0000_2d7c;
    t = rnd();
    strap = t[2:0];
    dev = {TYPE_C, t[2:0], 1'b0};
    foreach (mem[i]) mem[i] = 8'hFF;
    // Reset with a software reset pattern so the link side clears
    u_mst.start();
    repeat (9) u_mst.clk_bit(1'b1, ack);
    u_mst.start();
    u_mst.stop();
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    // Link side leaves reset only after three scl rises
    repeat (3) u_mst.clk_bit(1'b1, ack);

    // Wrong type code or strap bits: no ack
    for (int i = 1; i < 8; i++) begin
      u_mst.start();
      u_mst.wbyte(dev ^ (8'h01 << i), ack);
      check({7'h00, ack}, 8'h01, "foreign address");
      u_mst.stop();
    end
    $display("TB: test addressing done");

    // Erased array, read across the top of the array
    rd_rand(DEPTH - 2, 3);
    // Byte write, then current reads at n and n+1
    a = rnd_addr();
    wr(a, 1, 1);
    poll();
    rd_cur(1);
    rd_cur(1);
    // Page write of 34 bytes from offset 30, wrapping
    a = (rnd_addr() & ~31) | 30;
    wr(a, 34, 1);
    poll();
    rd_cur(1);
    rd_rand(a & ~31, 32);
    $display("TB: test write and read done");

    // Write cut by a repeated start is discarded
    a = rnd_addr();
    fill(2);
    wr_frame(a);
    rd_rand(a, 2);
    // Protect high throughout: nothing written, reads still work
    drive_wp(1'b1);
    a = rnd_addr();
    wr(a, 2, 0);
    repeat (10) @(negedge clock);
    check({7'h00, status.busy}, 8'h00, "protected busy");
    rd_rand(a, 2);
    // Protect dropped before the first data bit: write goes ahead
    a = rnd_addr();
    fork
      wr(a, 1, 1);
      begin
        #2000;
        drive_wp(1'b0);
      end
    join
    poll();
    rd_rand(a, 1);
    $display("TB: test protect done");

    // Protect raised after the first data bit cancels the write
    a = rnd_addr();
    fill(1);
    wr_frame(a);
    drive_wp(1'b1);
    repeat (3) @(negedge clock);
    u_mst.stop();
    repeat (10) @(negedge clock);
    check({7'h00, status.busy}, 8'h00, "cancel busy");
    check({7'h00, status.wr_cancel}, 8'h01, "cancel flag");
    drive_wp(1'b0);
    rd_rand(a, 1);
    // Protect raised during the write cycle aborts it at once
    a = rnd_addr();
    wr(a, 1, 0);
    for (int i = 0; i < 20 && status.busy !== 1'b1; i++) @(negedge clock);
    check({7'h00, status.busy}, 8'h01, "cycle busy");
    drive_wp(1'b1);
    repeat (5) @(negedge clock);
    check({7'h00, status.busy}, 8'h00, "abort busy");
    drive_wp(1'b0);
    addr_phase(1'b0, ack);
    check({7'h00, ack}, 8'h00, "standby ack");
    u_mst.stop();
    wr(a, 1, 1);
    poll();
    rd_rand(a, 1);
    // Start then stop inside a command starts nothing
    addr_phase(1'b0, ack);
    u_mst.start();
    u_mst.stop();
    repeat (6) @(negedge clock);
    check({7'h00, status.busy}, 8'h00, "cancel command");
    $display("TB: test cancel done");
    finish_test();
  end
endmodule
